// [logic/ibf_pkg.sv]
// Constants for the bus address match and arbitration flag block
package ibf_pkg;

    // ------------------------------------------------------------
    // Register indices on the plain register port
    // ------------------------------------------------------------
    localparam logic [3:0] IBF_REG_STATUS = 4'h0;
    localparam logic [3:0] IBF_REG_ADDR1 = 4'h1;
    localparam logic [3:0] IBF_REG_ADDR2 = 4'h2;
    localparam logic [3:0] IBF_REG_CTRL = 4'h3;
    localparam logic [3:0] IBF_REG_DATA = 4'h4;
    localparam logic [3:0] IBF_REG_IRQ_STAT = 4'h5;
    localparam logic [3:0] IBF_REG_IRQ_MASK = 4'h6;

    // ------------------------------------------------------------
    // Field positions of bus_status_flags
    // ------------------------------------------------------------
    localparam int IBF_BIT_CTI = 5;
    localparam int IBF_BIT_SECOND_ADDR_MATCH_FLAG = 4;
    localparam int IBF_BIT_AL = 3;
    localparam int IBF_BIT_AAS = 2;
    localparam int IBF_BIT_ADZ = 1;

    // ------------------------------------------------------------
    // Address registers: address in [7:1], format select in [0]
    // ------------------------------------------------------------
    localparam int IBF_BIT_FMT = 0;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int IBF_BIT_MASTER = 0;
    localparam int IBF_BIT_TRANSMIT = 1;
    localparam int IBF_BIT_ALSEL = 2;

    // ------------------------------------------------------------
    // Interrupt status and mask fields
    // ------------------------------------------------------------
    localparam int IBF_IRQ_ADDR = 0;
    localparam int IBF_IRQ_AL = 1;
    localparam int IBF_IRQ_GC = 2;
    localparam int IBF_IRQ_CTI = 3;

    // ------------------------------------------------------------
    // Reset values and frame constants
    // ------------------------------------------------------------
    localparam logic [7:0] IBF_RST_BYTE = 8'h00;
    localparam logic [3:0] IBF_RST_IRQ = 4'h0;
    localparam logic [7:0] IBF_GEN_CALL = 8'h00;
    localparam logic [2:0] IBF_LAST_BIT = 3'h7;
    localparam logic IBF_LINE_IDLE = 1'b1;

endpackage : ibf_pkg

// [logic/ibf_sync.sv]
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module ibf_sync
    import ibf_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Asynchronous in, synchronous out
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;

    // Idle bus level at reset so no false edge is seen on release
    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta_q <= IBF_LINE_IDLE;
            sync_out <= IBF_LINE_IDLE;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : ibf_sync
`default_nettype wire

// [logic/ibf_flags.sv]
// Address match, general call and arbitration lost flags of the bus interface
`timescale 1ns/100ps
`default_nettype none
module ibf_flags
    import ibf_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Bus pins, asynchronous
    input wire logic scl_pin,
    input wire logic sda_pin,
    // Frame engine, same clock
    input wire logic int_scl,
    input wire logic int_sda,
    input wire logic start_cmd,
    input wire logic data_reg_empty_flag,
    input wire logic data_reg_full_flag,
    // Status out
    output logic second_addr_match_flag,
    output logic arbitration_lost_flag,
    output logic slave_addr_match_flag,
    output logic general_call_flag,
    output logic continuous_transfer_irq_flag,
    output logic irq
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic scl_s;
    logic sda_s;

    ibf_sync u_scl_sync (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(scl_pin),
        .sync_out(scl_s)
    );

    ibf_sync u_sda_sync (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(sda_pin),
        .sync_out(sda_s)
    );

    // ------------------------------------------------------------
    // Edge and start detection
    // ------------------------------------------------------------
    logic scl_prev_q;
    logic sda_prev_q;
    logic scl_rise;
    logic scl_fall;
    logic start_det;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            scl_prev_q <= IBF_LINE_IDLE;
            sda_prev_q <= IBF_LINE_IDLE;
        end else begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    assign scl_rise = scl_s & ~scl_prev_q;
    assign scl_fall = ~scl_s & scl_prev_q;
    assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    logic [7:0] first_address_register_q;
    logic [7:0] second_address_register_q;
    logic [7:0] ctrl_q;
    logic [7:0] bus_data_register_q;
    logic [3:0] irq_mask_q;
    logic master_mode;
    logic transmit_mode;
    logic alsel;
    logic fs;
    logic second_format_select;
    logic slave_rx;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            first_address_register_q <= IBF_RST_BYTE;
            second_address_register_q <= IBF_RST_BYTE;
            ctrl_q <= IBF_RST_BYTE;
            bus_data_register_q <= IBF_RST_BYTE;
            irq_mask_q <= IBF_RST_IRQ;
        end else if (reg_wr) begin
            case (reg_addr)
                IBF_REG_ADDR1: first_address_register_q <= reg_wdata;
                IBF_REG_ADDR2: second_address_register_q <= reg_wdata;
                IBF_REG_CTRL: ctrl_q <= reg_wdata;
                IBF_REG_DATA: bus_data_register_q <= reg_wdata;
                IBF_REG_IRQ_MASK: irq_mask_q <= reg_wdata[3:0];
                default: ;
            endcase
        end
    end

    assign master_mode = ctrl_q[IBF_BIT_MASTER];
    assign transmit_mode = ctrl_q[IBF_BIT_TRANSMIT];
    assign alsel = ctrl_q[IBF_BIT_ALSEL];
    assign fs = first_address_register_q[IBF_BIT_FMT];
    assign second_format_select = second_address_register_q[IBF_BIT_FMT];
    assign slave_rx = ~master_mode & ~transmit_mode;

    // ------------------------------------------------------------
    // First frame capture after a start
    // ------------------------------------------------------------
    logic first_frame_q;
    logic [2:0] bit_cnt_q;
    logic [6:0] shift_q;
    logic [7:0] frame;
    logic frame_done;

    assign frame = {shift_q, sda_s};
    assign frame_done = first_frame_q & scl_rise & (bit_cnt_q == IBF_LAST_BIT);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            first_frame_q <= 1'b0;
            bit_cnt_q <= 3'h0;
            shift_q <= 7'h00;
        end else if (start_det) begin
            first_frame_q <= 1'b1;
            bit_cnt_q <= 3'h0;
        end else if (first_frame_q && scl_rise) begin
            shift_q <= frame[6:0];
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == IBF_LAST_BIT) begin
                first_frame_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Set conditions
    // ------------------------------------------------------------
    logic gen_call;
    logic match1;
    logic match2;
    logic set_second_addr_match_flag;
    logic set_aas;
    logic set_adz;
    logic set_al;
    logic set_cti;
    logic armed_q;
    logic empty_prev_q;
    logic full_prev_q;
    logic mst_tx;

    assign gen_call = (frame == IBF_GEN_CALL);
    assign match1 = (frame[7:1] == first_address_register_q[7:1]);
    assign match2 = (frame[7:1] == second_address_register_q[7:1]);
    assign mst_tx = master_mode & transmit_mode;

    assign set_second_addr_match_flag = frame_done & slave_rx & ~second_format_select & match2;
    assign set_aas = frame_done & slave_rx & ~fs & (match1 | gen_call);
    assign set_adz = frame_done & slave_rx & gen_call & (~fs | ~second_format_select);

    // Arm after a start command until our own data line goes low
    always_ff @(posedge core_clk) begin
        if (rst) begin
            armed_q <= 1'b0;
        end else if (start_cmd && mst_tx) begin
            armed_q <= 1'b1;
        end else if (!int_sda || !mst_tx) begin
            armed_q <= 1'b0;
        end
    end

    assign set_al = mst_tx & (
        (scl_rise & (int_sda != sda_s))
        | (~alsel & scl_fall & int_scl)
        | (alsel & armed_q & int_sda & ~sda_s));

    always_ff @(posedge core_clk) begin
        if (rst) begin
            empty_prev_q <= 1'b0;
            full_prev_q <= 1'b0;
        end else begin
            empty_prev_q <= data_reg_empty_flag;
            full_prev_q <= data_reg_full_flag;
        end
    end

    assign set_cti = ~master_mode & second_addr_match_flag
        & ((data_reg_empty_flag & ~empty_prev_q) | (data_reg_full_flag & ~full_prev_q));

    // ------------------------------------------------------------
    // Clear conditions
    // ------------------------------------------------------------
    logic [7:0] status_rd;
    logic [7:0] seen_q;
    logic [7:0] sw_clr;
    logic st_wr;
    logic st_rd;
    logic data_access;

    assign st_wr = reg_wr & (reg_addr == IBF_REG_STATUS);
    assign st_rd = reg_rd & (reg_addr == IBF_REG_STATUS);
    assign data_access = (reg_wr & (reg_addr == IBF_REG_DATA) & transmit_mode)
        | (reg_rd & (reg_addr == IBF_REG_DATA) & ~transmit_mode);

    assign status_rd = {2'b00, continuous_transfer_irq_flag, second_addr_match_flag,
        arbitration_lost_flag, slave_addr_match_flag, general_call_flag, 1'b0};

    // Clearing needs the bit read as one first; a blind zero write does nothing
    assign sw_clr = st_wr ? (~reg_wdata & seen_q) : 8'h00;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            seen_q <= IBF_RST_BYTE;
        end else if (st_rd) begin
            seen_q <= status_rd;
        end else if (st_wr) begin
            seen_q <= IBF_RST_BYTE;
        end
    end

    // ------------------------------------------------------------
    // Flags: set wins over every clear in the same cycle
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            second_addr_match_flag <= 1'b0;
            arbitration_lost_flag <= 1'b0;
            slave_addr_match_flag <= 1'b0;
            general_call_flag <= 1'b0;
            continuous_transfer_irq_flag <= 1'b0;
        end else begin
            if (set_second_addr_match_flag) begin
                second_addr_match_flag <= 1'b1;
            end else if (sw_clr[IBF_BIT_SECOND_ADDR_MATCH_FLAG] || start_det || master_mode) begin
                second_addr_match_flag <= 1'b0;
            end
            if (set_al) begin
                arbitration_lost_flag <= 1'b1;
            end else if (sw_clr[IBF_BIT_AL] || data_access) begin
                arbitration_lost_flag <= 1'b0;
            end
            if (set_aas) begin
                slave_addr_match_flag <= 1'b1;
            end else if (sw_clr[IBF_BIT_AAS] || data_access || master_mode) begin
                slave_addr_match_flag <= 1'b0;
            end
            if (set_adz) begin
                general_call_flag <= 1'b1;
            end else if (sw_clr[IBF_BIT_ADZ] || data_access || master_mode) begin
                general_call_flag <= 1'b0;
            end
            if (set_cti) begin
                continuous_transfer_irq_flag <= 1'b1;
            end else if (sw_clr[IBF_BIT_CTI]) begin
                continuous_transfer_irq_flag <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, mask and output
    // ------------------------------------------------------------
    logic [3:0] irq_stat_q;
    logic [3:0] irq_evt;
    logic [3:0] irq_w1c;

    always_comb begin
        irq_evt = 4'h0;
        irq_evt[IBF_IRQ_ADDR] = set_aas | set_second_addr_match_flag;
        irq_evt[IBF_IRQ_AL] = set_al;
        irq_evt[IBF_IRQ_GC] = set_adz;
        irq_evt[IBF_IRQ_CTI] = set_cti;
    end

    assign irq_w1c = (reg_wr && reg_addr == IBF_REG_IRQ_STAT) ? reg_wdata[3:0] : 4'h0;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_stat_q <= IBF_RST_IRQ;
            irq <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_w1c) | irq_evt;
            // One cycle behind the status bits; keeps the output a plain flop
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ------------------------------------------------------------
    // Read data, valid the cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= IBF_RST_BYTE;
        end else if (reg_rd) begin
            case (reg_addr)
                IBF_REG_STATUS: reg_rdata <= status_rd;
                IBF_REG_ADDR1: reg_rdata <= first_address_register_q;
                IBF_REG_ADDR2: reg_rdata <= second_address_register_q;
                IBF_REG_CTRL: reg_rdata <= ctrl_q;
                IBF_REG_DATA: reg_rdata <= bus_data_register_q;
                IBF_REG_IRQ_STAT: reg_rdata <= {4'h0, irq_stat_q};
                IBF_REG_IRQ_MASK: reg_rdata <= {4'h0, irq_mask_q};
                default: reg_rdata <= IBF_RST_BYTE;
            endcase
        end else begin
            reg_rdata <= IBF_RST_BYTE;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    sequence s_second_hit;
        frame_done && slave_rx && !second_format_select && match2;
    endsequence

    a_second_match_set: assert property (s_second_hit |=> second_addr_match_flag)
        else $error("second address match flag not set");

    a_second_master_clr: assert property (master_mode && !set_second_addr_match_flag |=> !second_addr_match_flag)
        else $error("second address match flag kept in master mode");

    a_al_rise_check: assert property (
        mst_tx && scl_rise && (int_sda != sda_s) |=> arbitration_lost_flag)
        else $error("arbitration lost missed on data mismatch");

    a_al_fall_check: assert property (
        mst_tx && !alsel && scl_fall && int_scl |=> arbitration_lost_flag)
        else $error("arbitration lost missed on clock fall");

    a_al_early_low: assert property (
        mst_tx && alsel && armed_q && int_sda && !sda_s |=> arbitration_lost_flag)
        else $error("arbitration lost missed on early low data");

    a_al_data_clr: assert property (
        arbitration_lost_flag && data_access && !set_al |=> !arbitration_lost_flag)
        else $error("arbitration lost not cleared by data access");

    a_match_gc_set: assert property (
        frame_done && slave_rx && !fs && gen_call |=> slave_addr_match_flag && general_call_flag)
        else $error("general call with first format zero not matched");

    a_gc_not_addr: assert property (
        frame_done && slave_rx && fs && !second_format_select && gen_call && !slave_addr_match_flag
        |=> general_call_flag && !slave_addr_match_flag)
        else $error("general call wrongly treated as addressed");

    a_master_clr_all: assert property (
        master_mode |=> !slave_addr_match_flag && !general_call_flag)
        else $error("match flags kept in master mode");

    a_write_one_noset: assert property (
        st_wr && !second_addr_match_flag && !set_second_addr_match_flag && !start_det
        |=> !second_addr_match_flag)
        else $error("write set a status flag");

    a_cti_set: assert property (
        !master_mode && second_addr_match_flag
        && ($rose(data_reg_empty_flag) || $rose(data_reg_full_flag))
        |=> continuous_transfer_irq_flag)
        else $error("continuous transfer flag not raised");

    a_reset_clear: assert property (disable iff (1'b0)
        rst |=> !second_addr_match_flag && !arbitration_lost_flag
        && !slave_addr_match_flag && !general_call_flag)
        else $error("flags not cleared by reset");

    a_irq_level: assert property (|(irq_stat_q & irq_mask_q) |=> irq)
        else $error("interrupt output not raised");

endmodule : ibf_flags
`default_nettype wire

// [tb/ibf_bus_partner.sv]
// Behavioural bus master standing on the far side of the serial pins
`timescale 1ns/100ps
`default_nettype none
module ibf_bus_partner (
    // Pin levels with the pull-up already resolved
    output logic scl_pin,
    output logic sda_pin
);
    localparam int HALF_NS = 400;

    initial begin
        scl_pin = 1'b1;
        sda_pin = 1'b1;
    end

    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    // Data moves only while the clock is low, so no false start or stop
    task automatic bit_cycle(input logic d);
        scl_pin = 1'b0;
        #(HALF_NS / 2) sda_pin = d;
        #(HALF_NS / 2) scl_pin = 1'b1;
        #(HALF_NS);
    endtask : bit_cycle

    // Start, eight bits msb first, then a released ninth bit; clock parks high
    task automatic send_frame(input logic [7:0] b);
        sda_pin = 1'b0;
        #(HALF_NS);
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(b[i]);
        end
        bit_cycle(1'b1);
    endtask : send_frame

    // Another device holding data low, or letting it go back to the pull-up
    task automatic pull_sda(input logic v);
        sda_pin = v;
    endtask : pull_sda
endmodule : ibf_bus_partner
`default_nettype wire

// [tb/ibf_flags_tb_top.sv]
// Self-checking bench for the address match and arbitration flags
`timescale 1ns/100ps
`default_nettype none
module ibf_flags_tb_top
    import ibf_pkg::*;
;
    logic core_clk;
    logic rst;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic scl_pin;
    logic sda_pin;
    logic int_scl;
    logic int_sda;
    logic start_cmd;
    logic data_reg_empty_flag;
    logic data_reg_full_flag;
    logic second_addr_match_flag;
    logic arbitration_lost_flag;
    logic slave_addr_match_flag;
    logic general_call_flag;
    logic continuous_transfer_irq_flag;
    logic irq;
    logic [7:0] flags_w;
    logic [7:0] rd;
    logic [7:0] a1;
    logic [7:0] a2;
    logic [7:0] f;
    int n_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int seed = 36;

    assign flags_w = {2'b00, continuous_transfer_irq_flag, second_addr_match_flag,
                      arbitration_lost_flag, slave_addr_match_flag, general_call_flag, 1'b0};

    ibf_flags dut_u (
        .core_clk(core_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .scl_pin(scl_pin), .sda_pin(sda_pin),
        .int_scl(int_scl), .int_sda(int_sda), .start_cmd(start_cmd),
        .data_reg_empty_flag(data_reg_empty_flag), .data_reg_full_flag(data_reg_full_flag),
        .second_addr_match_flag(second_addr_match_flag),
        .arbitration_lost_flag(arbitration_lost_flag),
        .slave_addr_match_flag(slave_addr_match_flag), .general_call_flag(general_call_flag),
        .continuous_transfer_irq_flag(continuous_transfer_irq_flag), .irq(irq)
    );

    ibf_bus_partner partner_u (
        .scl_pin(scl_pin),
        .sda_pin(sda_pin)
    );

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // Runaway guard: the whole run needs about 1900 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 10000) begin
            n_errors++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read

    // Covers the synchroniser and the one-cycle irq lag
    task automatic settle();
        repeat (3) @(posedge core_clk);
        #1;
    endtask : settle

    task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val

    function automatic logic [7:0] exp_flags(input logic [7:0] fr, input logic [7:0] s1,
                                             input logic [7:0] s2);
        logic gc;
        logic [7:0] e;
        gc = (fr == IBF_GEN_CALL);
        e = IBF_RST_BYTE;
        e[IBF_BIT_AAS] = !s1[IBF_BIT_FMT] && (fr[7:1] == s1[7:1] || gc);
        e[IBF_BIT_SECOND_ADDR_MATCH_FLAG] = !s2[IBF_BIT_FMT] && (fr[7:1] == s2[7:1]);
        e[IBF_BIT_ADZ] = gc && (!s1[IBF_BIT_FMT] || !s2[IBF_BIT_FMT]);
        return e;
    endfunction : exp_flags

    // Master mode first wipes whatever the previous frame left behind
    task automatic frame_case(input logic [7:0] fr, input logic [7:0] s1, input logic [7:0] s2);
        reg_write(IBF_REG_ADDR1, s1);
        reg_write(IBF_REG_ADDR2, s2);
        reg_write(IBF_REG_CTRL, 8'h01);
        settle();
        check_val("flags in master", IBF_RST_BYTE, flags_w);
        reg_write(IBF_REG_CTRL, 8'h00);
        partner_u.send_frame(fr);
        settle();
        check_val("flags after frame", exp_flags(fr, s1, s2), flags_w);
    endtask : frame_case

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        int_scl = 1'b0;
        int_sda = 1'b1;
        start_cmd = 1'b0;
        data_reg_empty_flag = 1'b0;
        data_reg_full_flag = 1'b0;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        a1 = ($random(seed) & 8'hFE) | 8'h02;
        a2 = {~a1[7], a1[6:0]};
        settle();
        check_val("flags at reset", IBF_RST_BYTE, flags_w);
        reg_read(IBF_REG_STATUS, rd);
        check_val("status at reset", IBF_RST_BYTE, rd);
        reg_read(4'hF, rd);
        check_val("unmapped read", 8'h00, rd);
        reg_write(IBF_REG_STATUS, 8'hFF);
        settle();
        check_val("ones written", IBF_RST_BYTE, flags_w);
        $display("test reset done");
        for (int m = 0; m < 4; m++) begin
            for (int k = 0; k < 4; k++) begin
                f = $random(seed);
                if (k == 0) f[7:1] = a1[7:1];
                if (k == 1) f[7:1] = a2[7:1];
                if (k == 2) f = IBF_GEN_CALL;
                frame_case(f, a1 | m[0], a2 | m[1]);
            end
        end
        $display("test address frames done");
        reg_write(IBF_REG_IRQ_STAT, 8'h0F);
        reg_write(IBF_REG_IRQ_MASK, 8'h0F);
        frame_case({a1[7:1], 1'b1}, a1, a2);
        check_val("irq out", 8'h01, {7'h00, irq});
        reg_read(IBF_REG_IRQ_STAT, rd);
        check_val("irq status", 8'h01 << IBF_IRQ_ADDR, rd);
        reg_write(IBF_REG_IRQ_MASK, 8'h00);
        settle();
        check_val("irq masked", 8'h00, {7'h00, irq});
        reg_write(IBF_REG_IRQ_STAT, 8'h0F);
        reg_write(IBF_REG_IRQ_MASK, 8'h0F);
        settle();
        check_val("irq cleared", 8'h00, {7'h00, irq});
        reg_write(IBF_REG_STATUS, 8'hFF);
        settle();
        check_val("ones kept", 8'h01 << IBF_BIT_AAS, flags_w);
        reg_read(IBF_REG_DATA, rd);
        settle();
        check_val("data read", IBF_RST_BYTE, flags_w);
        $display("test interrupt done");
        frame_case({a2[7:1], 1'b0}, a1, a2);
        f = $random(seed);
        data_reg_full_flag <= f[0];
        data_reg_empty_flag <= ~f[0];
        settle();
        data_reg_full_flag <= 1'b0;
        data_reg_empty_flag <= 1'b0;
        f = (8'h01 << IBF_BIT_SECOND_ADDR_MATCH_FLAG) | (8'h01 << IBF_BIT_CTI);
        check_val("continuous flag", f, flags_w);
        reg_read(IBF_REG_STATUS, rd);
        check_val("status read", f, rd);
        reg_write(IBF_REG_STATUS, 8'h00);
        settle();
        check_val("read then zero", IBF_RST_BYTE, flags_w);
        frame_case({a2[7:1], 1'b1}, a1, a2);
        partner_u.send_frame({a1[7:1], 1'b0});
        settle();
        check_val("start clears", 8'h01 << IBF_BIT_AAS, flags_w);
        $display("test second address done");
        reg_write(IBF_REG_CTRL, 8'h03);
        f = $random(seed);
        int_sda <= f[0];
        partner_u.bit_cycle(~f[0]);
        settle();
        check_val("data mismatch", 8'h01 << IBF_BIT_AL, flags_w);
        int_sda <= 1'b1;
        reg_write(IBF_REG_DATA, 8'h5A);
        partner_u.bit_cycle(1'b1);
        settle();
        check_val("data write", IBF_RST_BYTE, flags_w);
        int_scl <= 1'b1;
        partner_u.bit_cycle(1'b1);
        settle();
        check_val("clock high", 8'h01 << IBF_BIT_AL, flags_w);
        reg_read(IBF_REG_STATUS, rd);
        reg_write(IBF_REG_STATUS, 8'h00);
        reg_write(IBF_REG_CTRL, 8'h07);
        partner_u.bit_cycle(1'b1);
        settle();
        check_val("select one clock", IBF_RST_BYTE, flags_w);
        int_scl <= 1'b0;
        @(posedge core_clk);
        start_cmd <= 1'b1;
        @(posedge core_clk);
        start_cmd <= 1'b0;
        partner_u.pull_sda(1'b0);
        settle();
        check_val("pulled low first", 8'h01 << IBF_BIT_AL, flags_w);
        partner_u.pull_sda(1'b1);
        $display("test arbitration done");
        report_and_stop();
    end
endmodule : ibf_flags_tb_top
`default_nettype wire
